// ===== tcp_port.sv
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "tcp_cfg.svh"
// Operation
// RULE1: Address hold stretches SCL after eighth edge
// RULE2: Status and buffered address readable during hold
// RULE3: Release clock drives software chosen ack
// RULE4: Read request ack stretches and flags
// RULE5: Transmit load after ack sets full
// RULE6: Capture host ack on ninth pulse
// RULE7: Not-acknowledge releases SCL and SDA
// RULE8: Host mode overrides pin direction low
// RULE9: Start/stop bits cleared by reset, disable
// RULE10: Firmware host keeps only condition detectors
// RULE11: Host events set interrupt flag
// RULE12: No queuing; early buffer write collides
// RULE13: Generation suspends detection, flags on finish
// RULE14: Host first byte is address plus direction; host mode here only loads the buffer and never shifts it out
// RULE15: Host receive acknowledges each byte; host mode here has no receive, and only the client drives an ack
// RULE16: Repeated start keeps bus ownership
// RULE17: Released SCL halts generator until high
// RULE18: Buffer write during sequence sets collision
// RULE19: Low five control bits locked during start
// RULE20: Start waits one period with lines high
// RULE21: Second timeout ends start holding SDA
// RULE22: Start collision sets flag, returns idle
// RULE23: Client shifts on falling, latches ninth rising
// RULE24: Generator counts down reload, timeout unit
module tcp_port (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // Register port
    input wire logic [`TCP_ADDR_W-1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Bus pins
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE
);
    logic [7:0] con1;
    logic [7:0] con2;
    logic [6:0] own_addr;
    logic [7:0] baud;
    logic [7:0] buffer;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic buffer_full_flag, rw, da, ack_timing_status, start_det, stop_det;
    logic port_interrupt_flag, write_collision_flag, bus_collision_flag;
    logic scl_q, sda_q, scl_fall, scl_rise, start_cond, stop_cond;
    logic sda_low_drv, scl_low_drv, baud_load, baud_run, baud_to;
    logic wr_buf, rd_buf, host_mode, fw_host, client_mode, enabled;
    tcp_pkg::tcp_cstate_t cstate;
    tcp_pkg::tcp_hstate_t hstate;

    assign enabled = con1[`TCP_CON1_EN];
    assign host_mode = enabled && con1[3:0] == `TCP_MODE_HOST;
    assign fw_host = enabled && con1[3:0] == `TCP_MODE_FWHOST;
    assign client_mode = enabled && con1[3:0] == `TCP_MODE_CLIENT7;
    assign wr_buf = WR && ADDR == `TCP_REG_BUF;
    assign rd_buf = RD && ADDR == `TCP_REG_BUF;
    assign scl_fall = scl_q && !SCL_IN;
    assign scl_rise = !scl_q && SCL_IN;
    assign start_cond = sda_q && !SDA_IN && SCL_IN && scl_q;
    assign stop_cond = !sda_q && SDA_IN && SCL_IN && scl_q;

    // ------------------------------------------------------------
    // Pin drivers, open drain
    // ------------------------------------------------------------
    assign SCL_OUT = 1'b0;
    assign SDA_OUT = 1'b0;
    assign SCL_OE = scl_low_drv; // RULE8
    assign SDA_OE = sda_low_drv; // RULE8

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= SCL_IN;
            sda_q <= SDA_IN;
        end
    end

    // ------------------------------------------------------------
    // Baud rate generator
    // ------------------------------------------------------------
    tcp_baud #(
        .W(8)
    ) u_baud (
        .clk(CORE_CLK),
        .rstn(RSTN),
        .load(baud_load),
        .run(baud_run),
        .reload(baud),
        .timeout(baud_to)
    ); // RULE24

    // ------------------------------------------------------------
    // Host start generator
    // ------------------------------------------------------------
    always_comb begin
        baud_load = 1'b0;
        baud_run = hstate != tcp_pkg::HS_IDLE;
        if (host_mode && hstate == tcp_pkg::HS_IDLE
            && con2[`TCP_CON2_SEN] && SCL_IN && SDA_IN) begin
            baud_load = 1'b1; // RULE20
        end
        if (hstate == tcp_pkg::HS_WAIT1 && baud_to && SCL_IN && SDA_IN) begin
            baud_load = 1'b1; // RULE20
        end
        if (!SCL_IN && !scl_low_drv) begin
            baud_run = 1'b0; // RULE17
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN || !host_mode) begin
            hstate <= tcp_pkg::HS_IDLE;
        end else begin
            case (hstate)
                tcp_pkg::HS_IDLE: begin
                    if (con2[`TCP_CON2_SEN] && SCL_IN && SDA_IN) begin
                        hstate <= tcp_pkg::HS_WAIT1;
                    end
                end
                tcp_pkg::HS_WAIT1: begin
                    if (!SCL_IN) begin
                        hstate <= tcp_pkg::HS_IDLE; // RULE22
                    end else if (baud_to) begin
                        hstate <= SDA_IN ? tcp_pkg::HS_WAIT2
                                         : tcp_pkg::HS_IDLE;
                    end
                end
                tcp_pkg::HS_WAIT2: begin
                    if (baud_to) begin
                        hstate <= tcp_pkg::HS_IDLE; // RULE21
                    end
                end
                default: hstate <= tcp_pkg::HS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Client state machine
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN || !client_mode || start_cond || stop_cond) begin
            cstate <= tcp_pkg::CS_IDLE;
            bitcnt <= 4'h0;
            if (start_cond && client_mode) begin
                cstate <= tcp_pkg::CS_ADDR;
            end
        end else begin
            case (cstate)
                tcp_pkg::CS_ADDR: begin
                    if (scl_rise) begin
                        bitcnt <= bitcnt + 4'h1;
                    end
                    if (scl_fall && bitcnt == 4'h8) begin
                        bitcnt <= 4'h0;
                        if (shreg[7:1] != own_addr) begin
                            cstate <= tcp_pkg::CS_IDLE;
                        end else if (con1[`TCP_CON1_ADDRESS_HOLD_ENABLE]) begin
                            cstate <= tcp_pkg::CS_HOLD; // RULE1
                        end else begin
                            cstate <= tcp_pkg::CS_ACK;
                        end
                    end
                end
                tcp_pkg::CS_HOLD: begin
                    if (con1[`TCP_CON1_CKP]) begin
                        cstate <= tcp_pkg::CS_ACK; // RULE3
                    end
                end
                tcp_pkg::CS_ACK: begin
                    if (scl_fall) begin
                        if (con2[`TCP_CON2_ACK_DATA_BIT] || !rw) begin
                            cstate <= tcp_pkg::CS_IDLE; // RULE7
                        end else begin
                            cstate <= tcp_pkg::CS_STRETCH; // RULE4
                        end
                    end
                end
                tcp_pkg::CS_STRETCH: begin
                    if (con1[`TCP_CON1_CKP]) begin
                        cstate <= tcp_pkg::CS_TX; // RULE5
                    end
                end
                tcp_pkg::CS_TX: begin
                    if (scl_fall) begin
                        bitcnt <= bitcnt + 4'h1; // RULE23
                        if (bitcnt == 4'h7) begin
                            cstate <= tcp_pkg::CS_TXACK;
                        end
                    end
                end
                tcp_pkg::CS_TXACK: begin
                    if (scl_fall) begin
                        bitcnt <= 4'h0;
                        cstate <= con2[`TCP_CON2_ACK_STATUS_BIT]
                                  ? tcp_pkg::CS_IDLE // RULE7
                                  : tcp_pkg::CS_STRETCH; // RULE6
                    end
                end
                default: cstate <= tcp_pkg::CS_IDLE;
            endcase
        end
    end

    always_comb begin
        scl_low_drv = 1'b0;
        sda_low_drv = 1'b0;
        if (cstate == tcp_pkg::CS_HOLD || cstate == tcp_pkg::CS_STRETCH) begin
            scl_low_drv = 1'b1; // RULE1
        end
        if (cstate == tcp_pkg::CS_ACK && !con2[`TCP_CON2_ACK_DATA_BIT]) begin
            sda_low_drv = 1'b1; // RULE3 RULE15
        end
        if (cstate == tcp_pkg::CS_TX && !shreg[7]) begin
            sda_low_drv = 1'b1; // RULE23
        end
        if (hstate == tcp_pkg::HS_WAIT2) begin
            sda_low_drv = 1'b1; // RULE20
        end
        if (host_mode && hstate == tcp_pkg::HS_IDLE && start_det) begin
            sda_low_drv = 1'b1; // RULE16
        end
        if (fw_host) begin
            scl_low_drv = 1'b0; // RULE10
            sda_low_drv = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Shift register and buffer
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            shreg <= 8'h00;
            buffer <= 8'h00;
            buffer_full_flag <= 1'b0;
        end else begin
            if (cstate == tcp_pkg::CS_ADDR && scl_rise) begin
                shreg <= {shreg[6:0], SDA_IN};
            end
            if (cstate == tcp_pkg::CS_ADDR && scl_fall && bitcnt == 4'h8
                && shreg[7:1] == own_addr) begin
                buffer <= shreg; // RULE2
                buffer_full_flag <= 1'b1;
            end
            if (cstate == tcp_pkg::CS_TX && scl_fall) begin
                shreg <= {shreg[6:0], 1'b1}; // RULE23
            end
            if (cstate == tcp_pkg::CS_STRETCH && con1[`TCP_CON1_CKP]) begin
                shreg <= buffer; // RULE5
                buffer_full_flag <= 1'b0;
            end
            if (rd_buf) begin
                buffer_full_flag <= 1'b0; // RULE2
            end
            if (wr_buf) begin
                if (cstate == tcp_pkg::CS_STRETCH) begin
                    buffer <= WDATA; // RULE5
                    buffer_full_flag <= 1'b1;
                end else if (host_mode && hstate == tcp_pkg::HS_IDLE
                             && !con2[`TCP_CON2_SEN]) begin
                    buffer <= WDATA; // RULE14
                    buffer_full_flag <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Control and status registers
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            con1 <= 8'h00;
            con2 <= 8'h00;
            own_addr <= `TCP_RST_ADDR;
            baud <= `TCP_RST_BAUD;
        end else begin
            if (WR && ADDR == `TCP_REG_CON1) begin
                con1 <= WDATA;
            end else if (WR && ADDR == `TCP_REG_CON2) begin
                con2[7:5] <= WDATA[7:5];
                if (hstate == tcp_pkg::HS_IDLE && !con2[`TCP_CON2_SEN]) begin
                    con2[4:0] <= WDATA[4:0]; // RULE19
                end
            end else if (WR && ADDR == `TCP_REG_ADDR) begin
                own_addr <= WDATA[6:0];
            end else if (WR && ADDR == `TCP_REG_BAUD) begin
                baud <= WDATA;
            end
            if ((cstate == tcp_pkg::CS_ADDR && scl_fall && bitcnt == 4'h8
                 && con1[`TCP_CON1_ADDRESS_HOLD_ENABLE])
                || (cstate == tcp_pkg::CS_ACK && scl_fall && rw
                    && !con2[`TCP_CON2_ACK_DATA_BIT])
                || (cstate == tcp_pkg::CS_TXACK && scl_fall
                    && !con2[`TCP_CON2_ACK_STATUS_BIT])) begin
                con1[`TCP_CON1_CKP] <= 1'b0; // RULE4
            end
            if (cstate == tcp_pkg::CS_TXACK && scl_rise) begin
                con2[`TCP_CON2_ACK_STATUS_BIT] <= SDA_IN; // RULE6
            end
            if ((hstate == tcp_pkg::HS_WAIT2 && baud_to)
                || (hstate != tcp_pkg::HS_IDLE && !SCL_IN)
                || (hstate == tcp_pkg::HS_IDLE && con2[`TCP_CON2_SEN]
                    && !SCL_IN && !SDA_IN)) begin
                con2[`TCP_CON2_SEN] <= 1'b0; // RULE21
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RSTN || !enabled) begin
            start_det <= 1'b0; // RULE9
            stop_det <= 1'b0;
            rw <= 1'b0;
            da <= 1'b0;
            ack_timing_status <= 1'b0;
        end else begin
            if (start_cond && hstate == tcp_pkg::HS_IDLE) begin
                start_det <= 1'b1; // RULE13
                stop_det <= 1'b0;
            end else if (stop_cond && hstate == tcp_pkg::HS_IDLE) begin
                stop_det <= 1'b1; // RULE13
                start_det <= 1'b0;
            end
            if (hstate == tcp_pkg::HS_WAIT1 && baud_to && SCL_IN && SDA_IN) begin
                start_det <= 1'b1; // RULE20
                stop_det <= 1'b0;
            end
            if (cstate == tcp_pkg::CS_ADDR && scl_fall && bitcnt == 4'h8) begin
                rw <= shreg[0]; // RULE2
                da <= 1'b0;
                ack_timing_status <= 1'b0;
            end
            if (cstate == tcp_pkg::CS_HOLD || cstate == tcp_pkg::CS_ACK) begin
                ack_timing_status <= 1'b1; // RULE2
            end else if (cstate == tcp_pkg::CS_TX) begin
                ack_timing_status <= 1'b0;
                da <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Event flags: set wins over software clear
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            port_interrupt_flag <= 1'b0;
            write_collision_flag <= 1'b0;
            bus_collision_flag <= 1'b0;
        end else begin
            if (WR && ADDR == `TCP_REG_FLAG) begin
                port_interrupt_flag <= WDATA[`TCP_FLAG_IF];
                write_collision_flag <= WDATA[`TCP_FLAG_WRITE_COLLISION_FLAG];
                bus_collision_flag <= WDATA[`TCP_FLAG_BCL];
            end
            if ((cstate == tcp_pkg::CS_ADDR && scl_fall && bitcnt == 4'h8
                 && con1[`TCP_CON1_ADDRESS_HOLD_ENABLE] && shreg[7:1] == own_addr)
                || (cstate == tcp_pkg::CS_ACK && scl_fall && rw
                    && !con2[`TCP_CON2_ACK_DATA_BIT])
                || (cstate == tcp_pkg::CS_TXACK && scl_fall)) begin
                port_interrupt_flag <= 1'b1; // RULE1
            end
            if ((host_mode || fw_host) && hstate == tcp_pkg::HS_IDLE
                && (start_cond || stop_cond)) begin
                port_interrupt_flag <= 1'b1; // RULE11
            end
            if (hstate == tcp_pkg::HS_WAIT2 && baud_to) begin
                port_interrupt_flag <= 1'b1; // RULE13
            end
            if (wr_buf && (hstate != tcp_pkg::HS_IDLE
                           || con2[`TCP_CON2_SEN]
                           || cstate == tcp_pkg::CS_TX)) begin
                write_collision_flag <= 1'b1; // RULE12 RULE18
            end
            if ((hstate == tcp_pkg::HS_IDLE && host_mode
                 && con2[`TCP_CON2_SEN] && !SCL_IN && !SDA_IN)
                || (hstate != tcp_pkg::HS_IDLE && hstate != tcp_pkg::HS_WAIT2
                    && !SCL_IN)) begin
                bus_collision_flag <= 1'b1; // RULE22
            end
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            RDATA <= 8'h00;
        end else if (!RD) begin
            RDATA <= 8'h00;
        end else if (ADDR == `TCP_REG_CON1) begin
            RDATA <= con1;
        end else if (ADDR == `TCP_REG_CON2) begin
            RDATA <= con2;
        end else if (ADDR == `TCP_REG_STAT) begin
            RDATA <= {ack_timing_status, 1'b0, da, stop_det, start_det, rw,
                      1'b0, buffer_full_flag}; // RULE2
        end else if (ADDR == `TCP_REG_BUF) begin
            RDATA <= buffer;
        end else if (ADDR == `TCP_REG_ADDR) begin
            RDATA <= {1'b0, own_addr};
        end else if (ADDR == `TCP_REG_BAUD) begin
            RDATA <= baud;
        end else if (ADDR == `TCP_REG_FLAG) begin
            RDATA <= {5'h00, bus_collision_flag, write_collision_flag,
                      port_interrupt_flag};
        end else begin
            RDATA <= 8'h00;
        end
    end
endmodule : tcp_port

// ===== tcp_cfg.svh
`ifndef TCP_CFG_SVH
`define TCP_CFG_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define TCP_ADDR_W 4
`define TCP_REG_CON1 4'h0
`define TCP_REG_CON2 4'h1
`define TCP_REG_STAT 4'h2
`define TCP_REG_BUF 4'h3
`define TCP_REG_ADDR 4'h4
`define TCP_REG_BAUD 4'h5
`define TCP_REG_FLAG 4'h6
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define TCP_CON1_CKP 4
`define TCP_CON1_EN 5
`define TCP_CON1_ADDRESS_HOLD_ENABLE 6
`define TCP_CON2_SEN 0
`define TCP_CON2_PEN 2
`define TCP_CON2_ACK_DATA_BIT 5
`define TCP_CON2_ACK_STATUS_BIT 6
`define TCP_STAT_BF 0
`define TCP_STAT_RW 2
`define TCP_STAT_START 3
`define TCP_STAT_STOP 4
`define TCP_STAT_DA 5
`define TCP_STAT_ACK_TIMING_STATUS 7
`define TCP_FLAG_IF 0
`define TCP_FLAG_WRITE_COLLISION_FLAG 1
`define TCP_FLAG_BCL 2
// ------------------------------------------------------------
// Mode codes and reset values
// ------------------------------------------------------------
`define TCP_MODE_CLIENT7 4'h6
`define TCP_MODE_HOST 4'h8
`define TCP_MODE_FWHOST 4'hb
`define TCP_RST_BAUD 8'h09
`define TCP_RST_ADDR 7'h00
`endif

// ===== tcp_pkg.sv
package tcp_pkg;
    typedef enum logic [2:0] {
        CS_IDLE, CS_ADDR, CS_HOLD, CS_ACK, CS_STRETCH, CS_TX, CS_TXACK
    } tcp_cstate_t;
    typedef enum logic [1:0] {
        HS_IDLE, HS_WAIT1, HS_WAIT2
    } tcp_hstate_t;
endpackage : tcp_pkg

// ===== tcp_baud.sv
`timescale 1ns/10ps
module tcp_baud #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    input wire logic load,
    input wire logic run,
    input wire logic [W-1:0] reload,
    // Status
    output logic timeout
);
    logic [W-1:0] count;

    // Count down from reload; pulse at zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            count <= '0;
            timeout <= 1'b0;
        end else if (load) begin
            count <= reload;
            timeout <= 1'b0;
        end else if (run && count != '0) begin
            count <= count - 1'b1;
            timeout <= (count == {{(W-1){1'b0}}, 1'b1});
        end else begin
            timeout <= 1'b0;
        end
    end
endmodule : tcp_baud

// ===== tcp_port_assertions.sv
`timescale 1ns/10ps
module tcp_port_chk (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // Register port
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // Bus pins
    input wire logic SCL_IN,
    input wire logic SCL_OUT,
    input wire logic SCL_OE,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE
);
    // --------
    // Properties
    // --------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RSTN);
    a_pins_zero: assert property (!SCL_OUT && !SDA_OUT)
        else $error("Pin output level not zero");
    a_read_quiet: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("Read data outside read cycle");
    a_reset_idle: assert property (
        RSTN && !$past(RSTN) |-> !SDA_OE && !SCL_OE)
        else $error("Pins driven after reset");
    a_start_idle: assert property (
        $rose(SDA_OE) && SCL_IN |-> $past(SDA_IN, 8) && $past(SCL_IN, 8))
        else $error("Start without idle bus");
    a_start_hold: assert property (
        $rose(SDA_OE) && SCL_IN |=> SDA_OE [*8])
        else $error("Start level not held");
    a_shift_low: assert property (
        $fell(SDA_OE) && SCL_IN && $past(SCL_IN)
        |-> $past(WR) || $past(WR, 2))
        else $error("Data changed while clock high");
    a_release_write: assert property (
        $fell(SCL_OE) |-> $past(WR) || $past(WR, 2))
        else $error("Clock released without write");
    a_stretch_low: assert property (
        $rose(SCL_OE) |-> !SCL_IN && !$past(SCL_IN))
        else $error("Stretch began with clock high");
    c_start: cover property ($rose(SDA_OE) && SCL_IN);
    c_stretch: cover property ($rose(SCL_OE));
    c_release: cover property ($fell(SCL_OE));
endmodule : tcp_port_chk
bind tcp_port tcp_port_chk i_chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
    .WR(WR), .RD(RD), .RDATA(RDATA), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT),
    .SCL_OE(SCL_OE), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE));

// ===== tcp_host_model.sv
`timescale 1ns/10ps
module tcp_host_model (
    // Clock
    input wire logic clk,
    // Bus levels and pull-downs
    input wire logic scl,
    input wire logic sda,
    output logic scl_oe,
    output logic sda_oe
);
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    task automatic half;
        repeat (10) @(posedge clk);
    endtask : half
    task automatic hold(input logic on);
        @(posedge clk);
        scl_oe <= on;
        sda_oe <= on;
    endtask : hold
    task automatic start;
        @(posedge clk);
        sda_oe <= 1'b1;
        half();
        scl_oe <= 1'b1;
        half();
    endtask : start
    task automatic bit_x(input logic b, output logic r);
        sda_oe <= !b;
        half();
        scl_oe <= 1'b0;
        // Clock arbitration against client stretch
        for (int i = 0; i < 400 && !scl; i++) @(posedge clk);
        half();
        r = sda;
        scl_oe <= 1'b1;
        half();
    endtask : bit_x
    task automatic stop;
        sda_oe <= 1'b1;
        half();
        scl_oe <= 1'b0;
        half();
        sda_oe <= 1'b0;
        half();
    endtask : stop
endmodule : tcp_host_model

// ===== tcp_port_tb.sv
`timescale 1ns/10ps
`include "tcp_cfg.svh"
module tcp_port_tb;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [`TCP_ADDR_W-1:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic scl_oe;
    logic sda_oe;
    logic m_scl;
    logic m_sda;
    logic scl;
    logic sda;
    int mismatches = 0;
    int checks = 0;
    // Open-drain wires with pull-ups
    assign scl = !(scl_oe || m_scl);
    assign sda = !(sda_oe || m_sda);
    always #20 core_clk = ~core_clk;
    tcp_port i_dut (.CORE_CLK(core_clk), .RSTN(rstn), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SCL_IN(scl),
        .SCL_OUT(), .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(),
        .SDA_OE(sda_oe));
    tcp_host_model i_host (.clk(core_clk), .scl(scl), .sda(sda),
        .scl_oe(m_scl), .sda_oe(m_sda));
    // --------
    // Check, register access and finish tasks
    // --------
    task automatic chk(input string s, input logic [7:0] e,
        input logic [7:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : wreg
    task automatic rchk(input logic [3:0] a, input logic [7:0] m,
        input logic [7:0] e, input string s, input int n = 1);
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge core_clk);
            rd <= 1'b0;
            #1 d = rdata;
            if ((d & m) === e) break;
        end
        chk(s, e, d & m);
    endtask : rchk
    task automatic close_out;
        if (mismatches == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    // --------
    // Scenarios
    // --------
    task automatic t_reset;
        rchk(`TCP_REG_BAUD, 8'hff, `TCP_RST_BAUD, "baud");
        rchk(`TCP_REG_STAT, 8'hff, 8'h00, "stat");
        rchk(`TCP_REG_FLAG, 8'hff, 8'h00, "flag");
        rchk(4'hf, 8'hff, 8'h00, "unmapped");
    endtask : t_reset
    task automatic t_host_start;
        wreg(`TCP_REG_CON1, 8'h28);
        wreg(`TCP_REG_CON2, 8'h01);
        wreg(`TCP_REG_BUF, 8'h33);
        wreg(`TCP_REG_CON2, 8'h05);
        rchk(`TCP_REG_CON2, 8'h1f, 8'h01, "con2 lock");
        rchk(`TCP_REG_FLAG, 8'h02, 8'h02, "write_collision_flag");
        for (int n = 0; n < 100 && !sda_oe; n++) @(posedge core_clk);
        chk("start drive", 8'h03, {6'h0, scl, sda_oe});
        rchk(`TCP_REG_CON2, 8'h01, 8'h00, "start done", 50);
        chk("sda held", 8'h01, {7'h0, sda_oe});
        rchk(`TCP_REG_FLAG, 8'h01, 8'h01, "start irq");
        rchk(`TCP_REG_STAT, 8'h08, 8'h08, "start seen");
        rchk(`TCP_REG_BUF, 8'hff, 8'h00, "buffer kept");
        wreg(`TCP_REG_CON1, 8'h08);
        rchk(`TCP_REG_STAT, 8'h18, 8'h00, "disable");
        chk("sda free", 8'h00, {7'h0, sda_oe});
    endtask : t_host_start
    task automatic t_collision;
        i_host.hold(1'b1);
        wreg(`TCP_REG_FLAG, 8'h00);
        wreg(`TCP_REG_CON1, 8'h28);
        wreg(`TCP_REG_CON2, 8'h01);
        rchk(`TCP_REG_FLAG, 8'h04, 8'h04, "collision", 50);
        rchk(`TCP_REG_CON2, 8'h01, 8'h00, "aborted");
        chk("no start", 8'h00, {7'h0, sda_oe});
        i_host.hold(1'b0);
        wreg(`TCP_REG_CON1, 8'h2b);
        wreg(`TCP_REG_FLAG, 8'h00);
        i_host.start();
        rchk(`TCP_REG_FLAG, 8'h01, 8'h01, "fw start irq");
        chk("fw quiet", 8'h00, {6'h0, scl_oe, sda_oe});
        i_host.stop();
        rchk(`TCP_REG_STAT, 8'h18, 8'h10, "fw stop seen");
        wreg(`TCP_REG_CON1, 8'h00);
    endtask : t_collision
    task automatic t_client;
        logic [7:0] v;
        logic r;
        wreg(`TCP_REG_ADDR, 8'h2a);
        wreg(`TCP_REG_FLAG, 8'h00);
        wreg(`TCP_REG_CON1, 8'h66);
        i_host.start();
        v = 8'h55;
        for (int i = 7; i >= 0; i--) i_host.bit_x(v[i], r);
        chk("addr hold", 8'h01, {7'h0, scl_oe});
        rchk(`TCP_REG_FLAG, 8'h01, 8'h01, "hold irq");
        rchk(`TCP_REG_STAT, 8'ha5, 8'h85, "hold stat");
        rchk(`TCP_REG_BUF, 8'hff, 8'h55, "held addr");
        rchk(`TCP_REG_STAT, 8'h01, 8'h00, "bf clear");
        wreg(`TCP_REG_FLAG, 8'h00);
        wreg(`TCP_REG_CON2, 8'h00);
        wreg(`TCP_REG_CON1, 8'h76);
        i_host.bit_x(1'b1, r);
        chk("client ack", 8'h00, {7'h0, r});
        for (int k = 0; k < 2; k++) begin
            chk("read stretch", 8'h01, {7'h0, scl_oe});
            rchk(`TCP_REG_FLAG, 8'h01, 8'h01, "read irq");
            wreg(`TCP_REG_FLAG, 8'h00);
            wreg(`TCP_REG_BUF, k ? 8'h3c : 8'ha5);
            rchk(`TCP_REG_STAT, 8'h01, 8'h01, "bf set");
            wreg(`TCP_REG_CON1, 8'h76);
            for (int i = 7; i >= 0; i--) i_host.bit_x(1'b1, v[i]);
            chk("sent byte", k ? 8'h3c : 8'ha5, v);
            i_host.bit_x(k[0], r);
            rchk(`TCP_REG_CON2, 8'h40, k ? 8'h40 : 8'h00, "ack_status_bit");
        end
        chk("released", 8'h00, {6'h0, scl_oe, sda_oe});
        i_host.stop();
    endtask : t_client
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        t_reset();
        t_host_start();
        t_collision();
        t_client();
        close_out();
    end
endmodule : tcp_port_tb
